// ---- gpio_bank_with_irq.sv ----
`timescale 1ns/1ps
// Operation
// - 48 pins in three banks of sixteen; fourth bank has no GPIO.
// - After reset every pin belongs to the GPIO function.
// - Out of reset output drivers and input buffers are off.
// - Direction register bit per pin selects input or output.
// - Set register drives high the pins written as one.
// - Clear register drives low the pins written as one.
// - Toggle register inverts the pins written as one.
// - Data register writes the output value directly.
// - Status register reads the sensed pin levels.
// - Enable-set register turns on interrupts of pins written one.
// - Enable-clear register turns off interrupts of pins written one.
// - Inputs interrupt from the pin; outputs from the driven level.
// - Sensitivity register picks level or edge per pin.
// - Edge pins fire on rising only, or on both edges.
module gpio_bank_with_irq
   import gpio_pkg::*;
(
   input  wire logic                  clk,
   input  wire logic                  srst,
   input  wire logic [ADDR_W-1:0]     reg_addr,
   input  wire logic [DATA_W-1:0]     reg_wdata,
   input  wire logic                  reg_wr,
   input  wire logic                  reg_rd,
   output logic      [DATA_W-1:0]     reg_rdata,
   input  wire logic [PIN_COUNT-1:0]  pin_in,
   output logic      [PIN_COUNT-1:0]  pin_out,
   output logic      [PIN_COUNT-1:0]  pin_oe,
   output logic      [BANK_COUNT-1:0] irq
);

   // ****************************************************************
   // State
   // ****************************************************************
   typedef logic [BANK_COUNT-1:0][BANK_W-1:0] bank_vec_t;

   typedef struct packed {
      bank_vec_t             dir;
      bank_vec_t             out;
      bank_vec_t             out_prev;
      bank_vec_t             ien;
      bank_vec_t             sens;
      bank_vec_t             both;
      bank_vec_t             inen;
      logic [DATA_W-1:0]     rdata;
      logic [BANK_COUNT-1:0] irq;
   } gpio_state_t;

   gpio_state_t st_reg;
   gpio_state_t st_next;

   logic [1:0]        reg_bank;
   logic [3:0]        reg_idx;
   logic              addr_ok;
   logic              wr_hit;
   logic              rd_hit;
   logic [BANK_W-1:0] wd16;
   bank_vec_t         wmask;
   bank_vec_t         bmask;
   bank_vec_t         sync_lvl;
   bank_vec_t         sync_prev;
   bank_vec_t         sensed;
   bank_vec_t         src_lvl;
   bank_vec_t         src_prev;
   bank_vec_t         cond;

   // ****************************************************************
   // Pin synchronisers, one per bank
   // ****************************************************************
   for (genvar b = 0; b < BANK_COUNT; b++) begin : g_sense
      gpio_pin_sense #(
         .WIDTH      (BANK_W)
      ) u_sense (
         .clk        (clk),
         .srst       (srst),
         .pin_in     (pin_in[b*BANK_W +: BANK_W]),
         .level      (sync_lvl[b]),
         .level_prev (sync_prev[b])
      );
   end

   // ****************************************************************
   // Register port decode
   // ****************************************************************
   // Bank and word index from the byte address
   assign reg_bank = reg_addr[BANK_LSB +: 2];
   assign reg_idx  = reg_addr[IDX_LSB +: 4];
   assign wd16     = reg_wdata[BANK_W-1:0];

   assign addr_ok = (reg_addr[IDX_LSB-1:0] == 2'h0) && (reg_bank != BANK_NONE);
   assign wr_hit  = reg_wr && addr_ok;
   assign rd_hit  = reg_rd && addr_ok;

   // Write data and lane mask placed into the addressed bank
   always_comb begin
      wmask = '0;
      bmask = '0;
      for (int b = 0; b < BANK_COUNT; b++) begin
         if (wr_hit && (reg_bank == 2'(b))) begin
            wmask[b] = wd16;
            bmask[b] = 16'hffff;
         end
      end
   end

   // ****************************************************************
   // Interrupt condition per pin
   // ****************************************************************
   // Input buffer gate, source select and sensitivity
   always_comb begin
      for (int b = 0; b < BANK_COUNT; b++) begin
         sensed[b] = sync_lvl[b] & st_reg.inen[b];
         src_lvl[b]  = (st_reg.dir[b] & st_reg.out[b]) | (~st_reg.dir[b] & sensed[b]);
         src_prev[b] = (st_reg.dir[b] & st_reg.out_prev[b])
                     | (~st_reg.dir[b] & sync_prev[b] & st_reg.inen[b]);
         cond[b] = (~st_reg.sens[b] & src_lvl[b])
                 | (st_reg.sens[b] & ((src_lvl[b] & ~src_prev[b])
                 | (st_reg.both[b] & ~src_lvl[b] & src_prev[b])));
      end
   end

   // ****************************************************************
   // Next state
   // ****************************************************************
   // Register writes, read data and interrupt outputs
   always_comb begin
      st_next          = st_reg;
      st_next.out_prev = st_reg.out;
      st_next.rdata    = '0;
      if (wr_hit) begin
         unique case (reg_idx)
            IDX_DIR:     st_next.dir = (st_reg.dir & ~bmask) | wmask;
            IDX_DATA:    st_next.out = (st_reg.out & ~bmask) | wmask;
            IDX_SET:     st_next.out = st_reg.out | wmask;
            IDX_CLR:     st_next.out = st_reg.out & ~wmask;
            IDX_TOG:     st_next.out = st_reg.out ^ wmask;
            IDX_IEN_SET: st_next.ien = st_reg.ien | wmask;
            IDX_IEN_CLR: st_next.ien = st_reg.ien & ~wmask;
            IDX_SENS:    st_next.sens = (st_reg.sens & ~bmask) | wmask;
            IDX_BOTH:    st_next.both = (st_reg.both & ~bmask) | wmask;
            IDX_INEN:    st_next.inen = (st_reg.inen & ~bmask) | wmask;
            default:     st_next.out = st_reg.out; // Status and gaps ignore writes
         endcase
      end
      if (rd_hit) begin
         unique case (reg_idx)
            IDX_DIR:     st_next.rdata = {READ_PAD, st_reg.dir[reg_bank]};
            IDX_DATA:    st_next.rdata = {READ_PAD, st_reg.out[reg_bank]};
            IDX_STATUS:  st_next.rdata = {READ_PAD, sensed[reg_bank]};
            IDX_IEN_SET: st_next.rdata = {READ_PAD, st_reg.ien[reg_bank]};
            IDX_IEN_CLR: st_next.rdata = {READ_PAD, st_reg.ien[reg_bank]};
            IDX_SENS:    st_next.rdata = {READ_PAD, st_reg.sens[reg_bank]};
            IDX_BOTH:    st_next.rdata = {READ_PAD, st_reg.both[reg_bank]};
            IDX_INEN:    st_next.rdata = {READ_PAD, st_reg.inen[reg_bank]};
            default:     st_next.rdata = '0; // Write-only and gaps read zero
         endcase
      end
      for (int b = 0; b < BANK_COUNT; b++) begin
         st_next.irq[b] = |(st_reg.ien[b] & cond[b]);
      end
      if (srst) begin
         st_next.dir      = {BANK_COUNT{RST_DIR}};
         st_next.out      = {BANK_COUNT{RST_OUT}};
         st_next.out_prev = {BANK_COUNT{RST_OUT}};
         st_next.ien      = {BANK_COUNT{RST_IEN}};
         st_next.sens     = {BANK_COUNT{RST_SENS}};
         st_next.both     = {BANK_COUNT{RST_BOTH}};
         st_next.inen     = {BANK_COUNT{RST_INEN}};
         st_next.rdata    = '0;
         st_next.irq      = '0;
      end
   end

   // State register
   always_ff @(posedge clk) begin
      st_reg <= st_next;
   end

   // Outputs straight from the state register
   assign reg_rdata = st_reg.rdata;
   assign pin_out   = st_reg.out;
   assign pin_oe    = st_reg.dir;   // Driver on only for output pins
   assign irq       = st_reg.irq;

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);

   // Bank 0 pin 0 configured as the only interrupt source
   logic edge_cfg;
   logic lvl_cfg;
   logic out_cfg;
   assign edge_cfg = st_reg.inen[0][0] && !st_reg.dir[0][0] && st_reg.sens[0][0]
                  && (st_reg.ien[0] == 16'h0001);
   assign lvl_cfg  = st_reg.inen[0][0] && !st_reg.dir[0][0] && !st_reg.sens[0][0]
                  && (st_reg.ien[0] == 16'h0001);
   assign out_cfg  = st_reg.dir[0][0] && !st_reg.sens[0][0] && (st_reg.ien[0] == 16'h0001);

   sequence s_hold_both;
      (edge_cfg && st_reg.both[0][0]) [*2];
   endsequence

   sequence s_hold_rise;
      (edge_cfg && !st_reg.both[0][0]) [*2];
   endsequence

   sequence s_hold_level;
      lvl_cfg [*4];
   endsequence

   chk_set_bits: assert property (
      (wr_hit && reg_idx == IDX_SET) |=> pin_out == ($past(pin_out) | $past(wmask)))
      else $error("set write changed the wrong pins");

   chk_clr_bits: assert property (
      (wr_hit && reg_idx == IDX_CLR) |=> pin_out == ($past(pin_out) & ~$past(wmask)))
      else $error("clear write changed the wrong pins");

   chk_tog_bits: assert property (
      (wr_hit && reg_idx == IDX_TOG) |=> pin_out == ($past(pin_out) ^ $past(wmask)))
      else $error("toggle write changed the wrong pins");

   chk_data_write: assert property (
      (wr_hit && reg_idx == IDX_DATA)
      |=> pin_out == (($past(pin_out) & ~$past(bmask)) | $past(wmask)))
      else $error("data write did not set the bank value");

   chk_status_read: assert property (
      (rd_hit && reg_idx == IDX_STATUS)
      |=> reg_rdata == {READ_PAD, $past(sync_lvl[reg_bank] & st_reg.inen[reg_bank])})
      else $error("status read did not return the sensed levels");

   chk_ien_set: assert property (
      (wr_hit && reg_idx == IDX_IEN_SET) |=> st_reg.ien == ($past(st_reg.ien) | $past(wmask)))
      else $error("enable set changed the wrong enables");

   chk_ien_clr: assert property (
      (wr_hit && reg_idx == IDX_IEN_CLR) |=> st_reg.ien == ($past(st_reg.ien) & ~$past(wmask)))
      else $error("enable clear changed the wrong enables");

   chk_drive_dir: assert property (
      (|(pin_oe & ~$past(pin_oe))) |-> $past(wr_hit && reg_idx == IDX_DIR))
      else $error("driver turned on without a direction write");

   chk_fourth_bank: assert property (
      (reg_rd && reg_bank == BANK_NONE) |=> reg_rdata == 32'h0)
      else $error("fourth bank read returned data");

   chk_out_irq: assert property (
      ($past(out_cfg) && out_cfg) |-> irq[0] == $past(st_reg.out[0][0]))
      else $error("output pin interrupt does not follow the driven level");

   chk_level_irq: assert property (
      s_hold_level |-> irq[0] == $past(pin_in[0], 3))
      else $error("level interrupt does not follow the pin");

   chk_both_edge: assert property (
      ($fell(pin_in[0]) && edge_cfg && st_reg.both[0][0]) ##1 s_hold_both |=> irq[0])
      else $error("falling edge missed in both-edge mode");

   chk_rise_only: assert property (
      ($fell(pin_in[0]) && edge_cfg && !st_reg.both[0][0]) ##1 s_hold_rise |=> !irq[0])
      else $error("falling edge fired in rising-only mode");

   chk_rise_edge: assert property (
      ($rose(pin_in[0]) && edge_cfg) ##1 edge_cfg [*2] |=> irq[0])
      else $error("rising edge did not raise the interrupt");

   chk_rdata_idle: assert property (
      !$past(rd_hit) |-> reg_rdata == 32'h0)
      else $error("read data present without a read");

   chk_irq_masked: assert property (
      (st_reg.ien == '0) |=> irq == '0)
      else $error("interrupt raised with all enables off");

   chk_reset_state: assert property (
      $past(srst) |-> (pin_oe == '0) && (pin_out == '0) && (irq == '0))
      else $error("outputs not cleared by reset");

endmodule

// ---- gpio_board_model.sv ----
`timescale 1ns/1ps
// ****************************************************************
// Board side of the shared pads
// ****************************************************************
module gpio_board_model
   import gpio_pkg::*;
(
   input  wire logic [PIN_COUNT-1:0] pin_out,
   input  wire logic [PIN_COUNT-1:0] pin_oe,
   input  wire logic [PIN_COUNT-1:0] ext_level,
   output logic      [PIN_COUNT-1:0] pin_in
);
   // direction picks driver
   // Pad level: chip drives enabled outputs, board drives the rest
   always_comb begin
      for (int i = 0; i < PIN_COUNT; i++) begin
         pin_in[i] = pin_oe[i] ? pin_out[i] : ext_level[i];
      end
   end
endmodule

// ---- gpio_pin_sense.sv ----
`timescale 1ns/1ps
// ****************************************************************
// Two-stage pin synchroniser with one delayed copy for edges
// ****************************************************************
module gpio_pin_sense
   import gpio_pkg::*;
#(
   parameter int WIDTH = BANK_W
) (
   input  wire logic             clk,
   input  wire logic             srst,
   input  wire logic [WIDTH-1:0] pin_in,
   output logic      [WIDTH-1:0] level,
   output logic      [WIDTH-1:0] level_prev
);

   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] level;
      logic [WIDTH-1:0] prev;
   } sense_state_t;

   sense_state_t s_reg;
   sense_state_t s_next;

   // Next state: meta only feeds the second stage
   always_comb begin
      s_next = s_reg;
      s_next.meta  = pin_in;
      s_next.level = s_reg.meta;
      s_next.prev  = s_reg.level;
      if (srst) begin
         s_next = '0;
      end
   end

   // State register
   always_ff @(posedge clk) begin
      s_reg <= s_next;
   end

   assign level      = s_reg.level;
   assign level_prev = s_reg.prev;

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);

   chk_sync_delay: assert property (
      (!$past(srst) && !$past(srst, 2)) |-> (level == $past(pin_in, 2)))
      else $error("synchronised level is not the pin two cycles back");

endmodule

// ---- gpio_pkg.sv ----
// ****************************************************************
// Bank geometry and register map
// ****************************************************************
package gpio_pkg;

   // Bank geometry: three GPIO banks of sixteen pins each
   localparam int BANK_COUNT = 3;
   localparam int BANK_W     = 16;
   localparam int PIN_COUNT  = 48;
   localparam int ADDR_W     = 8;
   localparam int DATA_W     = 32;

   // Address fields: bank in bits 7:6, word index in bits 5:2
   localparam int BANK_LSB = 6;
   localparam int IDX_LSB  = 2;

   // Fourth port group: carries no GPIO, reads as zero
   localparam logic [1:0] BANK_NONE = 2'h3;

   // Word indices inside a bank
   localparam logic [3:0] IDX_DIR     = 4'h0;
   localparam logic [3:0] IDX_DATA    = 4'h1;
   localparam logic [3:0] IDX_SET     = 4'h2;
   localparam logic [3:0] IDX_CLR     = 4'h3;
   localparam logic [3:0] IDX_TOG     = 4'h4;
   localparam logic [3:0] IDX_STATUS  = 4'h5;
   localparam logic [3:0] IDX_IEN_SET = 4'h6;
   localparam logic [3:0] IDX_IEN_CLR = 4'h7;
   localparam logic [3:0] IDX_SENS    = 4'h8;
   localparam logic [3:0] IDX_BOTH    = 4'h9;
   localparam logic [3:0] IDX_INEN    = 4'ha;

   // Values after reset
   localparam logic [15:0] RST_DIR  = 16'h0000;
   localparam logic [15:0] RST_OUT  = 16'h0000;
   localparam logic [15:0] RST_IEN  = 16'h0000;
   localparam logic [15:0] RST_SENS = 16'h0000;
   localparam logic [15:0] RST_BOTH = 16'h0000;
   localparam logic [15:0] RST_INEN = 16'h0000;

   // Upper read data bits above a bank word
   localparam logic [15:0] READ_PAD = 16'h0000;

endpackage

// ---- tb.sv ----
`timescale 1ns/1ps
// ****************************************************************
// Testbench
// ****************************************************************
module tb
   import gpio_pkg::*;
();
   logic                  clk;
   logic                  srst;
   logic [ADDR_W-1:0]     reg_addr;
   logic [DATA_W-1:0]     reg_wdata;
   logic                  reg_wr;
   logic                  reg_rd;
   logic [DATA_W-1:0]     reg_rdata;
   logic [PIN_COUNT-1:0]  pin_in;
   logic [PIN_COUNT-1:0]  pin_out;
   logic [PIN_COUNT-1:0]  pin_oe;
   logic [PIN_COUNT-1:0]  ext_level;
   logic [BANK_COUNT-1:0] irq;
   logic [PIN_COUNT-1:0]  out_all;
   logic [PIN_COUNT-1:0]  oe_all;
   logic [15:0]           lfsr_state;
   logic [15:0]           v;
   logic [31:0]           rd;
   int                    num_errors;
   int                    n_tests;
   int                    hi;
   int                    p;

   gpio_bank_with_irq gpio_bank_with_irq_inst (.clk(clk), .srst(srst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .irq(irq));
   gpio_board_model gpio_board_model_inst (.pin_out(pin_out), .pin_oe(pin_oe),
      .ext_level(ext_level), .pin_in(pin_in));

   // Clock at 200 MHz
   always #2.5 clk = ~clk;

   // ****************************************************************
   // Helpers
   // ****************************************************************
   function automatic logic [15:0] rnd();
      for (int i = 0; i < 16; i++) begin
         lfsr_state = {lfsr_state[14:0],
                       lfsr_state[15] ^ lfsr_state[13] ^ lfsr_state[12] ^ lfsr_state[10]};
      end
      return lfsr_state;
   endfunction

   task automatic check(string name, logic [47:0] seen, logic [47:0] exp);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic finish_test();
      if (num_errors == 0 && n_tests > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic wr(int b, logic [3:0] idx, logic [15:0] d);
      @(posedge clk);
      reg_wr    <= 1'b1;
      reg_addr  <= {b[1:0], idx, 2'h0};
      reg_wdata <= {16'h0000, d};
      @(posedge clk);
      reg_wr <= 1'b0;
      #1;
   endtask

   task automatic rdr(int b, logic [3:0] idx, output logic [31:0] d);
      @(posedge clk);
      reg_rd   <= 1'b1;
      reg_addr <= {b[1:0], idx, 2'h0};
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask

   // Count cycles with the bank interrupt high
   task automatic count_irq(int b, int n, output int highs);
      highs = 0;
      repeat (n) begin
         @(posedge clk);
         #1;
         if (irq[b] === 1'b1) highs++;
      end
   endtask

   // Hang guard
   initial begin
      repeat (100000) @(posedge clk);
      num_errors++;
      finish_test();
   end

   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      clk        = 1'b0;
      srst       = 1'b1;
      reg_wr     = 1'b0;
      reg_rd     = 1'b0;
      reg_addr   = 8'h00;
      reg_wdata  = 32'h0;
      ext_level  = '0;
      lfsr_state = 16'h005e;
      num_errors = 0;
      n_tests    = 0;
      out_all    = '0;
      oe_all     = '0;
      repeat (3) @(posedge clk);
      srst <= 1'b0;
      #1;
      // Reset state of pads and configuration
      check("pin_oe", pin_oe, 48'h0);
      check("pin_out", pin_out, 48'h0);
      for (int b = 0; b < 3; b++) begin
         rdr(b, IDX_DIR, rd);
         check("dir", 48'(rd), 48'h0);
         rdr(b, IDX_INEN, rd);
         check("inen", 48'(rd), 48'h0);
         rdr(b, IDX_IEN_SET, rd);
         check("ien", 48'(rd), 48'h0);
      end
      // Direction and output latch per bank, random values
      for (int b = 0; b < 3; b++) begin
         v = rnd();
         wr(b, IDX_DIR, v);
         oe_all[b*16+:16] = v;
         check("pin_oe", pin_oe, oe_all);
         v = rnd();
         wr(b, IDX_DATA, v);
         out_all[b*16+:16] = v;
         check("pin_out", pin_out, out_all);
         v = rnd();
         wr(b, IDX_SET, v);
         out_all[b*16+:16] |= v;
         check("pin_out", pin_out, out_all);
         v = rnd();
         wr(b, IDX_CLR, v);
         out_all[b*16+:16] &= ~v;
         check("pin_out", pin_out, out_all);
         v = rnd();
         wr(b, IDX_TOG, v);
         out_all[b*16+:16] ^= v;
         check("pin_out", pin_out, out_all);
         wr(b, IDX_SET, 16'h0000);
         wr(b, IDX_CLR, 16'h0000);
         check("pin_out", pin_out, out_all);
         rdr(b, IDX_DATA, rd);
         check("data", 48'(rd), 48'(out_all[b*16+:16]));
         rdr(b, IDX_DIR, rd);
         check("dir", 48'(rd), 48'(oe_all[b*16+:16]));
      end
      // Fourth group holds no pins
      wr(3, IDX_DATA, 16'hffff);
      wr(3, IDX_DIR, 16'hffff);
      check("pin_out", pin_out, out_all);
      check("pin_oe", pin_oe, oe_all);
      rdr(3, IDX_DATA, rd);
      check("bank3", 48'(rd), 48'h0);
      // Sensing: all inputs, buffers off then on
      for (int b = 0; b < 3; b++) begin
         wr(b, IDX_DIR, 16'h0000);
      end
      @(posedge clk);
      ext_level <= {rnd(), rnd(), rnd()};
      repeat (4) @(posedge clk);
      rdr(1, IDX_STATUS, rd);
      check("status", 48'(rd), 48'h0);
      for (int b = 0; b < 3; b++) begin
         wr(b, IDX_INEN, 16'hffff);
         repeat (3) @(posedge clk);
         rdr(b, IDX_STATUS, rd);
         check("status", 48'(rd), 48'(ext_level[b*16+:16]));
      end
      // Interrupts per bank on pin b*5
      for (int b = 0; b < 3; b++) begin
         p = b * 16 + b * 5;
         v = 16'h0001 << (b * 5);
         @(posedge clk);
         ext_level[p] <= 1'b0;
         wr(b, IDX_IEN_SET, v);
         rdr(b, IDX_IEN_SET, rd);
         check("ien", 48'(rd), 48'(v));
         @(posedge clk);
         ext_level[p] <= 1'b1;
         repeat (4) @(posedge clk);
         count_irq(b, 5, hi);
         check("irq_level", 48'(hi), 48'h5);
         wr(b, IDX_IEN_CLR, v);
         rdr(b, IDX_IEN_CLR, rd);
         check("ien_clr", 48'(rd), 48'h0);
         count_irq(b, 5, hi);
         check("irq_masked", 48'(hi), 48'h0);
         @(posedge clk);
         ext_level[p] <= 1'b0;
         wr(b, IDX_SENS, v);
         wr(b, IDX_BOTH, 16'h0000);
         wr(b, IDX_IEN_SET, v);
         repeat (4) @(posedge clk);
         for (int k = 0; k < 4; k++) begin
            if (k == 2) begin
               wr(b, IDX_BOTH, v);
            end
            @(posedge clk);
            ext_level[p] <= (k % 2 == 0);
            count_irq(b, 8, hi);
            check("irq_edge", 48'(hi), (k == 1) ? 48'h0 : 48'h1);
         end
         rdr(b, IDX_SENS, rd);
         check("sens", 48'(rd), 48'(v));
         rdr(b, IDX_BOTH, rd);
         check("both", 48'(rd), 48'(v));
         // Output pin fires from the driven level, edge then level mode
         wr(b, IDX_CLR, v);
         wr(b, IDX_DIR, v);
         repeat (4) @(posedge clk);
         wr(b, IDX_TOG, v);
         count_irq(b, 8, hi);
         check("irq_output", 48'(hi), 48'h1);
         wr(b, IDX_SENS, 16'h0000);
         count_irq(b, 4, hi);
         check("irq_out_level", 48'(hi), 48'h4);
         wr(b, IDX_CLR, v);
         repeat (2) @(posedge clk);
         count_irq(b, 4, hi);
         check("irq_out_low", 48'(hi), 48'h0);
         wr(b, IDX_IEN_CLR, v);
         wr(b, IDX_DIR, 16'h0000);
      end
      // Reset in mid-run clears latch, interrupts and configuration
      @(posedge clk);
      srst <= 1'b1;
      repeat (3) @(posedge clk);
      srst <= 1'b0;
      #1;
      check("pin_out", pin_out, 48'h0);
      check("irq", 48'(irq), 48'h0);
      rdr(0, IDX_INEN, rd);
      check("inen", 48'(rd), 48'h0);
      finish_test();
   end
endmodule
